// ===== bench/dcs_chk_sva.sv
/* Checker of dcs_top port behaviour, bound to every dcs_top.
   Assumes one clock and an active-low asynchronous reset. */
`default_nettype none
module dcs_chk (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Control writes and settings
    input wire logic i_wr_stb,
    input wire logic [2:0] i_wr_group,
    input wire logic [7:0] i_wr_data,
    input wire logic [15:0] i_port_a_start,
    input wire logic [15:0] i_port_b_start,
    input wire logic [15:0] i_block_len,
    input wire logic i_pulse_en,
    input wire logic i_auto_restart,
    // Bus and streams
    input wire logic o_bus_req,
    input wire logic i_bus_ack,
    input wire logic i_rd_valid,
    input wire logic o_rd_ready,
    input wire logic o_wr_valid,
    input wire logic i_wr_ready,
    // Results
    input wire logic [15:0] o_port_a_addr,
    input wire logic [15:0] o_port_b_addr,
    input wire logic o_pulse,
    input wire logic o_int_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    wire cmd = i_wr_stb && i_wr_group == 3'h6;
    wire load = cmd && i_wr_data == 8'hcf;
    wire clr = load || (cmd && (i_wr_data == 8'hd3 || i_wr_data == 8'hc3));
    wire take = i_rd_valid && o_rd_ready;
    wire drain = o_wr_valid && i_wr_ready;
    logic dir_q, fix_a_q, fix_b_q;
    logic [16:0] n_q;
    logic [3:0] occ_q;
    // ==========================================
    // Settings as last written, bytes since clear, FIFO fill
    always_ff @(posedge i_mclk)
    begin
        if (i_wr_stb && i_wr_group == 3'h0)
            dir_q <= i_wr_data[2];
        if (i_wr_stb && i_wr_group == 3'h1)
            fix_a_q <= i_wr_data[5];
        if (i_wr_stb && i_wr_group == 3'h2)
            fix_b_q <= i_wr_data[5];
    end
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            n_q <= 17'h0;
            occ_q <= 4'h0;
        end
        else
        begin
            n_q <= clr ? 17'h0 : n_q + {16'h0, take};
            occ_q <= occ_q + {3'h0, take} - {3'h0, drain};
        end
    end
    // ==========================================
    // Assertions
    load_a_a: assert property (load && (!fix_a_q || dir_q)
        |=> o_port_a_addr == $past(i_port_a_start)) else $error("port a load missed");
    load_b_a: assert property (load && (!fix_b_q || !dir_q)
        |=> o_port_b_addr == $past(i_port_b_start)) else $error("port b load missed");
    fixed_dest_a: assert property (load && fix_b_q && dir_q
        |=> $stable(o_port_b_addr)) else $error("fixed destination reloaded");
    cmd_off_a: assert property (cmd && i_wr_data != 8'h87 && i_wr_data != 8'h8b
        |=> !o_bus_req) else $error("request kept after control byte");
    pulse_once_a: assert property (o_pulse |-> i_pulse_en ##1 !o_pulse)
        else $error("pulse without enable or too long");
    int_hold_a: assert property (o_bus_req && i_bus_ack |-> o_int_n)
        else $error("interrupt while bus master");
    req_clean_a: assert property ($rose(o_bus_req) |-> o_int_n)
        else $error("request with ready interrupt pending");
    take_gate_a: assert property (o_rd_ready |-> o_bus_req && i_bus_ack)
        else $error("byte taken without bus");
    block_end_a: assert property (!i_auto_restart
        |-> n_q <= {1'b0, i_block_len} + 17'h1) else $error("ran past block end");
    fifo_fill_a: assert property (occ_q <= 4'h8 && (!o_wr_valid || occ_q != 4'h0))
        else $error("fifo count out of range");
endmodule // dcs_chk
bind dcs_top dcs_chk dcs_chk_inst (.*);
`default_nettype wire

// ===== bench/dcs_far_model.sv
/* Far side of the sequencer: bus arbiter, read source and write sink.
   Assumes the device's valid/ready streams and level bus request. */
`default_nettype none
module dcs_far_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Device side
    input wire logic i_bus_req,
    output logic o_bus_ack,
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte,
    output logic o_wr_ready,
    // Stall of the write sink
    input wire logic i_hold
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] seq_q;
    // Grant one cycle after request, take the bus back one cycle after request drops
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_bus_ack <= 1'b0;
            seq_q <= 8'ha5;
        end
        else
        begin
            o_bus_ack <= i_bus_req;
            if (o_rd_valid && i_rd_ready)
                seq_q <= seq_q + 8'h3b;
        end
    end
    assign o_rd_valid = o_bus_ack;
    // Data line shows no stale byte outside a transfer
    assign o_rd_byte = o_rd_valid ? seq_q : ~seq_q;
    assign o_wr_ready = ~i_hold;
endmodule // dcs_far_model
`default_nettype wire

// ===== bench/test_dma_counter_command_sequencer.sv
/* Self-checking bench of the sequencer with its far-side model.
   Assumes dcs_top, dcs_far_model and the bound checker. */
`default_nettype none
module test_dma_counter_command_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_reset_n = 1'b0, i_wr_stb = 1'b0, i_rd_stb = 1'b0, hold = 1'b1;
    logic [2:0] i_wr_group = 3'h0;
    logic [7:0] i_wr_data = 8'h00, i_pulse_byte = 8'h03;
    logic [15:0] i_port_a_start = 16'hfffb, i_port_b_start = 16'h0, i_block_len = 16'h9;
    logic i_pulse_en = 1'b1, i_auto_restart = 1'b0, i_ready_pin = 1'b0;
    logic i_ready_int_en = 1'b0, i_match_hit = 1'b0, i_stop_on_match = 1'b0;
    logic [7:0] o_rd_data, i_rd_byte, o_wr_byte;
    logic [15:0] o_port_a_addr, o_port_b_addr, bs, ra;
    logic o_bus_req, i_bus_ack, i_rd_valid, o_rd_ready, o_wr_valid, i_wr_ready;
    logic o_pulse, o_int_n;
    logic [31:0] rng_q = 32'h00007dc1;
    logic [7:0] exp_q [$];
    int checked = 0, mismatches = 0, moved = 0, pulses = 0;
    // ==========================================
    // Helpers
    function automatic logic [15:0] next_rand();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q[15:0];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] g, input logic [7:0] d);
        for (int k = 0; k < 300 && i_bus_ack !== 1'b0; k++) tick(1);
        i_wr_stb = 1'b1;
        i_wr_group = g;
        i_wr_data = d;
        tick(1);
        i_wr_stb = 1'b0;
        tick(1);
    endtask
    task automatic rd_all(input logic [1:0] st, input logic [15:0] n, a, b);
        logic [7:0] r [7];
        wr(3'h6, 8'ha7);
        for (int i = 0; i < 7; i++)
        begin
            r[i] = o_rd_data;
            i_rd_stb = 1'b1;
            tick(1);
            i_rd_stb = 1'b0;
            tick(1);
        end
        cmp({14'h0, r[0][5:4]}, {14'h0, st}, "status");
        cmp({r[2], r[1]}, n, "byte count");
        cmp({r[4], r[3]}, a, "port a address");
        cmp({r[6], r[5]}, b, "port b address");
    endtask
    task automatic run(input int n);
        for (int k = 0; k < 600 && moved < n; k++) tick(1);
        tick(6);
        cmp(moved, n, "bytes moved");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================
    // Design, far side and clock
    dcs_top dcs_top_inst (.*);
    dcs_far_model dcs_far_model_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_bus_req(o_bus_req), .o_bus_ack(i_bus_ack), .i_rd_ready(o_rd_ready),
        .o_rd_valid(i_rd_valid), .o_rd_byte(i_rd_byte), .o_wr_ready(i_wr_ready),
        .i_hold(hold));
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    // Every byte read is noted, every byte written must match the oldest
    always @(posedge i_mclk)
    begin
        if (i_rd_valid && o_rd_ready)
            exp_q.push_back(i_rd_byte);
        if (o_wr_valid && i_wr_ready)
        begin
            moved++;
            cmp(o_wr_byte, exp_q.pop_front(), "written byte");
        end
        if (o_pulse === 1'b1)
            pulses++;
    end
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
    // ==========================================
    // Scenarios
    initial
    begin
        tick(4);
        i_reset_n = 1'b1;
        tick(1);
        rd_all(2'h3, 16'h0, 16'h0, 16'h0);
        wr(3'h6, 8'h83);
        wr(3'h6, 8'hc3);
        bs = next_rand();
        i_port_b_start = bs;
        wr(3'h1, 8'h10);
        wr(3'h2, 8'h20);
        wr(3'h0, 8'h00);
        wr(3'h6, 8'hcf);
        i_port_b_start = ~bs;
        wr(3'h0, 8'h04);
        wr(3'h6, 8'hcf);
        ra = next_rand();
        i_port_a_start = ra;
        rd_all(2'h3, 16'h0, 16'hfffb, bs);
        i_ready_pin = 1'b1;
        wr(3'h6, 8'h87);
        tick(30);
        cmp(o_rd_ready, 1'b0, "full fifo refuses");
        hold = 1'b0;
        run(10);
        cmp(pulses, 1, "pulse count");
        rd_all(2'h1, 16'h000a, 16'hfffb + 16'h000a, bs);
        wr(3'h6, 8'hab);
        wr(3'h6, 8'h8b);
        rd_all(2'h3, 16'h000a, 16'h0005, bs);
        wr(3'h6, 8'hd3);
        wr(3'h6, 8'h8b);
        rd_all(2'h3, 16'h0, 16'h0005, bs);
        i_ready_pin = 1'b0;
        i_ready_int_en = 1'b1;
        wr(3'h6, 8'hab);
        wr(3'h6, 8'h87);
        i_ready_pin = 1'b1;
        tick(10);
        cmp(o_int_n, 1'b0, "ready interrupt");
        cmp(o_bus_req, 1'b0, "request held back");
        wr(3'h6, 8'ha3);
        cmp(o_int_n, 1'b1, "interrupt reset");
        wr(3'h6, 8'h87);
        tick(8);
        cmp(o_bus_req, 1'b0, "latched until rearm");
        moved = 0;
        wr(3'h6, 8'hb7);
        wr(3'h6, 8'h87);
        run(10);
        i_ready_pin = 1'b0;
        i_ready_int_en = 1'b0;
        wr(3'h6, 8'hcf);
        moved = 0;
        wr(3'h6, 8'hb3);
        wr(3'h6, 8'h87);
        run(10);
        rd_all(2'h1, 16'h000a, ra + 16'h000a, bs);
        wr(3'h6, 8'hb3);
        wr(3'h6, 8'hcf);
        wr(3'h6, 8'h87);
        tick(10);
        cmp(o_bus_req, 1'b0, "load clears forced ready");
        moved = 0;
        i_stop_on_match = 1'b1;
        i_match_hit = 1'b1;
        wr(3'h6, 8'hb3);
        wr(3'h3, 8'h40);
        run(1);
        rd_all(2'h2, 16'h0001, ra + 16'h0001, bs);
        i_match_hit = 1'b0;
        wr(3'h6, 8'hc3);
        rd_all(2'h3, 16'h0, ra + 16'h0001, bs);
        complete_run();
    end
endmodule // test_dma_counter_command_sequencer
`default_nettype wire

// ===== common/dcs_regs.vh
/*
 * Constants of the DMA counting and command sequencer: command codes,
 * control byte decode fields, read register indexes and status bits.
 * Assumes the includer is plain Verilog-2005.
 */
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
// Command group codes
`define DCS_CMD_RESET 8'hc3
`define DCS_CMD_RESET_A_TIMING 8'hc7
`define DCS_CMD_RESET_B_TIMING 8'hcb
`define DCS_CMD_LOAD 8'hcf
`define DCS_CMD_CONTINUE 8'hd3
`define DCS_CMD_DISABLE_INT 8'haf
`define DCS_CMD_ENABLE_INT 8'hab
`define DCS_CMD_RESET_DIS_INT 8'ha3
`define DCS_CMD_REARM 8'hb7
`define DCS_CMD_READ_STATUS 8'hbf
`define DCS_CMD_REINIT_STATUS 8'h8b
`define DCS_CMD_INIT_READ_SEQ 8'ha7
`define DCS_CMD_FORCE_READY 8'hb3
`define DCS_CMD_ENABLE 8'h87
`define DCS_CMD_DISABLE 8'h83
`define DCS_CMD_READ_MASK 8'hbb
// Group select codes (written byte decode on a pseudo register select)
`define DCS_SEL_BASE 3'h0
`define DCS_SEL_PORT_A_CFG 3'h1
`define DCS_SEL_PORT_B_CFG 3'h2
`define DCS_SEL_MASK_MATCH 3'h3
`define DCS_SEL_PORT_B_ADDR 3'h4
`define DCS_SEL_READY_POL 3'h5
`define DCS_SEL_COMMAND 3'h6
// Field positions
`define DCS_BASE_DIR_BIT 2
`define DCS_CFG_FIXED_BIT 5
`define DCS_CFG_INC_BIT 4
`define DCS_MM_ENABLE_BIT 6
`define DCS_MM_EVT_BIT 7
// Status bits
`define DCS_ST_REQ_BIT 0
`define DCS_ST_RDY_BIT 1
`define DCS_ST_IP_BIT 3
`define DCS_ST_NOMATCH_BIT 4
`define DCS_ST_NOEOB_BIT 5
// Read register indexes
`define DCS_RR_STATUS 3'h0
`define DCS_RR_COUNT_LO 3'h1
`define DCS_RR_COUNT_HI 3'h2
`define DCS_RR_A_LO 3'h3
`define DCS_RR_A_HI 3'h4
`define DCS_RR_B_LO 3'h5
`define DCS_RR_B_HI 3'h6
`define DCS_FIFO_DEPTH 8
`endif

// ===== logic/dcs_top.v
/*
 * DMA counting and command sequencer with its data FIFO.
 * Assumes the host writes control bytes and reads back only while it owns
 * the bus; data bytes from the read cycle arrive on a valid/ready stream.
 */
// Notes on behaviour
// - Byte counter is sixteen bits, cleared only by load, continue, reset and auto restart at end of block.
// - Counter increments at each read end, compared with block length.
// - Every byte whose read began is written, even after stopping.
// - End-of-block stop moves one byte past the block length.
// - Pulse byte compared with counter low byte after every byte.
// - Port A address counter loaded by load, then inc, dec or fixed.
// - Port B address counter behaves the same with its own settings.
// - Any control byte disables requests, except enable and listed ones.
// - Load puts a fixed address only into the current source port.
// - Start addresses may change anytime; used after load or auto restart.
// - Ready interrupt sets a latch; rearm command clears it.
// - Ready interrupt before bus request; others held until bus release.
// - Disable, enable and reset-and-disable interrupt commands accepted.
// - Reinitialise status sets match and end-of-block status bits to one.
// - End-of-block status bit reads zero once end-of-block is reached.
// - Force ready cleared by reset, load, int reset, stops, bus release.
`include "dcs_regs.vh"
`default_nettype none

// ==================================================================
// Data FIFO
module dcs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset_n,
    // Fill side
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    // Drain side
    output wire o_valid,
    input wire i_ready,
    output wire [WIDTH-1:0] o_data
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wp_q;
    reg [AW:0] rp_q;
    wire full;
    wire empty;
    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rp_q[AW-1:0]];
    always @(posedge i_mclk)
    begin
        if (i_valid && !full)
            mem[wp_q[AW-1:0]] <= i_data;
    end
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (i_valid && !full)
                wp_q <= wp_q + 1'b1;
            if (i_ready && !empty)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule // dcs_fifo

// ==================================================================
// Sequencer core
module dcs_top (
    // Clock and reset
    input wire i_mclk,
    input wire i_reset_n,
    // Control byte port
    input wire i_wr_stb,
    input wire [2:0] i_wr_group,
    input wire [7:0] i_wr_data,
    input wire i_rd_stb,
    output reg [7:0] o_rd_data,
    // Bus ownership
    output wire o_bus_req,
    input wire i_bus_ack,
    // Start addresses and block length, already assembled
    input wire [15:0] i_port_a_start,
    input wire [15:0] i_port_b_start,
    input wire [15:0] i_block_len,
    input wire [7:0] i_pulse_byte,
    input wire i_pulse_en,
    input wire i_auto_restart,
    // Ready pin and events
    input wire i_ready_pin,
    input wire i_ready_int_en,
    input wire i_match_hit,
    input wire i_stop_on_match,
    // Read-cycle data stream
    input wire i_rd_valid,
    output wire o_rd_ready,
    input wire [7:0] i_rd_byte,
    // Write-cycle data stream
    output wire o_wr_valid,
    input wire i_wr_ready,
    output wire [7:0] o_wr_byte,
    // Addresses and events out
    output reg [15:0] o_port_a_addr,
    output reg [15:0] o_port_b_addr,
    output reg o_pulse,
    output wire o_int_n
);
    // Next address by config: fixed, increment or decrement, wraps
    function [15:0] step_addr;
        input [15:0] a;
        input [7:0] cfg;
        begin
            if (cfg[`DCS_CFG_FIXED_BIT])
                step_addr = a;
            else if (cfg[`DCS_CFG_INC_BIT])
                step_addr = a + 16'h0001;
            else
                step_addr = a - 16'h0001;
        end
    endfunction

    reg [7:0] base_q;
    reg [7:0] cfg_a_q;
    reg [7:0] cfg_b_q;
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg en_q;
    reg force_q;
    reg req_seen_q;
    reg ready_latch_q;
    reg int_en_q;
    reg ip_q;
    reg nomatch_q;
    reg noeob_q;
    reg stop_q;
    reg [2:0] rsel_q;
    reg rdy_s1_q;
    reg rdy_s2_q;
    reg rdy_prev_q;
    wire is_cmd;
    wire c_reset;
    wire c_load;
    wire c_cont;
    wire c_load_or_reset;
    wire a_is_src;
    wire rd_take;
    wire rdy_int;
    wire fifo_in_ready;
    wire ready_ok;
    wire eob;
    wire match_stop;
    wire rdy_rise;

    assign is_cmd = i_wr_stb && (i_wr_group == `DCS_SEL_COMMAND);
    assign c_reset = is_cmd && (i_wr_data == `DCS_CMD_RESET);
    assign c_load = is_cmd && (i_wr_data == `DCS_CMD_LOAD);
    assign c_cont = is_cmd && (i_wr_data == `DCS_CMD_CONTINUE);
    assign c_load_or_reset = c_reset || c_load || c_cont;
    assign a_is_src = base_q[`DCS_BASE_DIR_BIT];
    assign ready_ok = rdy_s2_q || force_q;
    // Request only when enabled, ready, not stopped and not held by ready int
    assign o_bus_req = en_q && ready_ok && !stop_q && !ready_latch_q && !rdy_int;
    // A read may start only while requesting; the write side drains freely
    assign rd_take = i_rd_valid && o_rd_ready;
    assign o_rd_ready = o_bus_req && i_bus_ack && fifo_in_ready;
    assign eob = rd_take && (count_q == i_block_len);
    assign match_stop = rd_take && i_match_hit && i_stop_on_match;
    assign rdy_rise = rdy_s2_q && !rdy_prev_q;
    assign o_int_n = !(ip_q && !i_bus_ack);
    assign rdy_int = rdy_rise && i_ready_int_en && int_en_q && en_q && !i_bus_ack;

    dcs_fifo #(
        .WIDTH(8),
        .DEPTH(`DCS_FIFO_DEPTH)
    ) dcs_fifo_inst (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_valid(rd_take),
        .o_ready(fifo_in_ready),
        .i_data(i_rd_byte),
        .o_valid(o_wr_valid),
        .i_ready(i_wr_ready),
        .o_data(o_wr_byte)
    );

    always @*
    begin
        count_d = count_q;
        if (c_load_or_reset)
            count_d = 16'h0000;
        else if (eob && i_auto_restart)
            count_d = 16'h0000;
        else if (rd_take)
            count_d = count_q + 16'h0001;
    end

    // ==================================================================
    // Ready pin synchroniser
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_prev_q <= 1'b0;
        end
        else
        begin
            rdy_s1_q <= i_ready_pin;
            rdy_s2_q <= rdy_s1_q;
            rdy_prev_q <= rdy_s2_q;
        end
    end

    // ==================================================================
    // Control, counters and status
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            base_q <= 8'h00;
            cfg_a_q <= 8'h00;
            cfg_b_q <= 8'h00;
            count_q <= 16'h0000;
            o_port_a_addr <= 16'h0000;
            o_port_b_addr <= 16'h0000;
            en_q <= 1'b0;
            force_q <= 1'b0;
            req_seen_q <= 1'b0;
            ready_latch_q <= 1'b0;
            int_en_q <= 1'b0;
            ip_q <= 1'b0;
            nomatch_q <= 1'b1;
            noeob_q <= 1'b1;
            stop_q <= 1'b0;
            rsel_q <= `DCS_RR_STATUS;
            o_pulse <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            o_pulse <= 1'b0;
            if (o_bus_req)
                req_seen_q <= 1'b1;
            // Counting on each byte read
            if (rd_take)
            begin
                o_port_a_addr <= step_addr(o_port_a_addr, cfg_a_q);
                o_port_b_addr <= step_addr(o_port_b_addr, cfg_b_q);
                if (i_pulse_en && (count_d[7:0] == i_pulse_byte))
                    o_pulse <= 1'b1;
            end
            if (eob)
            begin
                noeob_q <= 1'b0;
                if (i_auto_restart)
                begin
                    o_port_a_addr <= i_port_a_start;
                    o_port_b_addr <= i_port_b_start;
                end
                else
                begin
                    stop_q <= 1'b1;
                    force_q <= 1'b0;
                end
                if (int_en_q)
                    ip_q <= 1'b1;
            end
            if (match_stop)
            begin
                nomatch_q <= 1'b0;
                stop_q <= 1'b1;
                force_q <= 1'b0;
                if (int_en_q)
                    ip_q <= 1'b1;
            end
            if (!i_bus_ack && o_bus_req == 1'b0 && req_seen_q && stop_q)
                force_q <= 1'b0;
            if (i_bus_ack && !o_bus_req)
                force_q <= 1'b0;
            // Control byte writes
            if (i_wr_stb)
            begin
                if (!(is_cmd && (i_wr_data == `DCS_CMD_ENABLE))
                    && !(is_cmd && (i_wr_data == `DCS_CMD_REINIT_STATUS))
                    && !(i_wr_group == `DCS_SEL_MASK_MATCH
                         && i_wr_data[`DCS_MM_ENABLE_BIT]))
                    en_q <= 1'b0;
                case (i_wr_group)
                    `DCS_SEL_BASE: base_q <= i_wr_data;
                    `DCS_SEL_PORT_A_CFG: cfg_a_q <= i_wr_data;
                    `DCS_SEL_PORT_B_CFG: cfg_b_q <= i_wr_data;
                    `DCS_SEL_MASK_MATCH:
                        if (i_wr_data[`DCS_MM_ENABLE_BIT])
                            en_q <= 1'b1;
                    default: ;
                endcase
            end
            if (is_cmd)
            begin
                case (i_wr_data)
                    `DCS_CMD_RESET:
                    begin
                        force_q <= 1'b0;
                        stop_q <= 1'b0;
                        nomatch_q <= 1'b1;
                        noeob_q <= 1'b1;
                        ip_q <= 1'b0;
                        int_en_q <= 1'b0;
                        ready_latch_q <= 1'b0;
                    end
                    `DCS_CMD_LOAD:
                    begin
                        force_q <= 1'b0;
                        stop_q <= 1'b0;
                        noeob_q <= 1'b1;
                        req_seen_q <= 1'b0;
                        // Fixed port loads only as source
                        if (a_is_src || !cfg_a_q[`DCS_CFG_FIXED_BIT])
                            o_port_a_addr <= i_port_a_start;
                        if (!a_is_src || !cfg_b_q[`DCS_CFG_FIXED_BIT])
                            o_port_b_addr <= i_port_b_start;
                    end
                    `DCS_CMD_CONTINUE:
                    begin
                        stop_q <= 1'b0;
                        noeob_q <= 1'b1;
                    end
                    `DCS_CMD_REINIT_STATUS:
                    begin
                        nomatch_q <= 1'b1;
                        noeob_q <= 1'b1;
                        stop_q <= 1'b0;
                    end
                    `DCS_CMD_FORCE_READY: force_q <= 1'b1;
                    `DCS_CMD_ENABLE: en_q <= 1'b1;
                    `DCS_CMD_REARM: ready_latch_q <= 1'b0;
                    `DCS_CMD_DISABLE_INT: int_en_q <= 1'b0;
                    `DCS_CMD_ENABLE_INT: int_en_q <= 1'b1;
                    `DCS_CMD_RESET_DIS_INT:
                    begin
                        ip_q <= 1'b0;
                        int_en_q <= 1'b0;
                        force_q <= 1'b0;
                    end
                    `DCS_CMD_READ_STATUS: rsel_q <= `DCS_RR_STATUS;
                    `DCS_CMD_INIT_READ_SEQ: rsel_q <= `DCS_RR_STATUS;
                    default: ;
                endcase
            end
            // Ready interrupt raised before requesting; wins over a same-cycle command
            if (rdy_int)
            begin
                ready_latch_q <= 1'b1;
                ip_q <= 1'b1;
            end
            // Read pointer steps through the sequence
            if (i_rd_stb)
                rsel_q <= (rsel_q == `DCS_RR_B_HI) ? `DCS_RR_STATUS : rsel_q + 3'h1;
        end
    end

    // ==================================================================
    // Read data
    always @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rd_data <= 8'h00;
        else
        begin
            case (rsel_q)
                `DCS_RR_STATUS: o_rd_data <= {2'b00, noeob_q, nomatch_q, !ip_q, 1'b0,
                                              rdy_s2_q, req_seen_q};
                `DCS_RR_COUNT_LO: o_rd_data <= count_q[7:0];
                `DCS_RR_COUNT_HI: o_rd_data <= count_q[15:8];
                `DCS_RR_A_LO: o_rd_data <= o_port_a_addr[7:0];
                `DCS_RR_A_HI: o_rd_data <= o_port_a_addr[15:8];
                `DCS_RR_B_LO: o_rd_data <= o_port_b_addr[7:0];
                `DCS_RR_B_HI: o_rd_data <= o_port_b_addr[15:8];
                default: o_rd_data <= 8'h00;
            endcase
        end
    end
endmodule // dcs_top
`default_nettype wire
